// ### rtl/ddri_init_ctrl.sv
// ddr2 power-up initialisation controller with apb control registers
// Function
// - termination control is held low through power-up and initialisation
// - only nops for at least 200 us, then clock enable goes high
// - wait at least 400 ns more, then precharge all first
// - load mode to extended register 2 with bank 1 high, bank 0 low
// - load mode to extended register 3 with both bank bits high
// - enable dll through extended register, a0 low, calibration bits zero
// - reset dll through main register with relock bit high, cke high
// - then precharge all, two refreshes, one dummy write
// - program main register again with relock bit low
// - extended register with calibration ones, then again with zeros
// - main register selected with both bank bits zero
// - every mode write carries the full register value
// - load mode only with banks idle; wait mode set delay after
// - test mode bit always written zero
// - cas latency field limited to 3 through 6
// - write recovery field limited to 2 through 6 clocks
// - after dll reset wait 200 clocks before any read
`include "ddri_consts.svh"

module ddri_init_ctrl #(
  parameter int P_ADDR_W = 13,
  parameter int P_CK_DIV = `DDRI_CK_DIV,
  parameter int P_WAIT_W = 16,
  parameter int P_INIT_CK = (`DDRI_T_INIT_NS + `DDRI_CLK_NS * `DDRI_CK_DIV - 1)
                            / (`DDRI_CLK_NS * `DDRI_CK_DIV),
  parameter int P_PRE_CK = (`DDRI_T_PRE_NS + `DDRI_CLK_NS * `DDRI_CK_DIV - 1)
                           / (`DDRI_CLK_NS * `DDRI_CK_DIV),
  parameter int P_DLL_CK = `DDRI_DLL_CK,
  parameter int P_MRD_CK = `DDRI_MODE_SET_DELAY_CK,
  parameter int P_RP_CK = `DDRI_RP_CK,
  parameter int P_RFC_CK = `DDRI_RFC_CK,
  parameter int P_WGAP_CK = `DDRI_WRITE_GAP_CK
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // memory command pins
  output logic o_ck,
  output logic o_ck_n,
  output logic o_cke,
  output logic o_odt,
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [1:0] o_ba,
  output logic [P_ADDR_W-1:0] o_addr
);
  localparam int HALF = P_CK_DIV / 2;
  localparam int DIV_W = $clog2(P_CK_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(P_CK_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(HALF);
  // full count: a start lands anywhere inside a ck period, so one tick is partial
  localparam logic [P_WAIT_W-1:0] LD_INIT = P_WAIT_W'(P_INIT_CK);
  localparam logic [P_WAIT_W-1:0] LD_PRE = P_WAIT_W'(P_PRE_CK - 1);
  localparam logic [P_WAIT_W-1:0] LD_DLL = P_WAIT_W'(P_DLL_CK - 1);
  localparam logic [P_WAIT_W-1:0] LD_MRD = P_WAIT_W'(P_MRD_CK - 1);
  localparam logic [P_WAIT_W-1:0] LD_RP = P_WAIT_W'(P_RP_CK - 1);
  localparam logic [P_WAIT_W-1:0] LD_RFC = P_WAIT_W'(P_RFC_CK - 1);
  localparam logic [P_WAIT_W-1:0] LD_WGAP = P_WAIT_W'(P_WGAP_CK - 1);

  // registers
  logic [P_ADDR_W-1:0] mr;
  logic [P_ADDR_W-1:0] emr;
  logic [P_ADDR_W-1:0] emr2;
  logic [P_ADDR_W-1:0] emr3;
  logic cfg_err;
  logic [DIV_W-1:0] div_cnt;
  logic [1:0] ref_cnt;
  ddri_pkg::ddri_state_t state;

  // combinational
  ddri_pkg::ddri_state_t next_state;
  logic [3:0] next_cmd;
  logic [1:0] next_ba;
  logic [P_ADDR_W-1:0] next_addr;
  logic [P_WAIT_W-1:0] next_gap;
  logic next_dll_load;

  // ck made here by dividing i_clk; commands change on its falling edge
  wire [DIV_W-1:0] next_div = (div_cnt == DIV_LAST) ? '0 : div_cnt + DIV_W'(1);
  wire tick = (next_div == DIV_HALF);
  wire ck_high = (next_div < DIV_HALF);

  // apb decode
  wire acc = i_psel && i_penable && o_pready;
  wire wr = acc && i_pwrite;
  wire sel_ctrl = (i_paddr == `DDRI_OFF_CTRL);
  wire sel_stat = (i_paddr == `DDRI_OFF_STATUS);
  wire sel_mr = (i_paddr == `DDRI_OFF_MR);
  wire sel_emr = (i_paddr == `DDRI_OFF_EMR);
  wire sel_emr2 = (i_paddr == `DDRI_OFF_EMR2);
  wire sel_emr3 = (i_paddr == `DDRI_OFF_EMR3);
  wire mapped = sel_ctrl || sel_stat || sel_mr || sel_emr || sel_emr2 || sel_emr3;
  wire idle = (state == ddri_pkg::ST_OFF) || (state == ddri_pkg::ST_READY);
  wire busy = !idle;
  // mode registers frozen while a sequence runs so each write is whole
  wire wr_mode = wr && idle;

  // configuration check before a sequence may start
  wire [2:0] bl_f = mr[`DDRI_BL_MSB:`DDRI_BL_LSB];
  wire [2:0] cl_f = mr[`DDRI_CL_MSB:`DDRI_CL_LSB];
  wire [2:0] wr_f = mr[`DDRI_WR_MSB:`DDRI_WR_LSB];
  wire bl_ok = (bl_f == `DDRI_BL_4) || (bl_f == `DDRI_BL_8);
  wire cl_ok = (cl_f >= `DDRI_CL_MIN) && (cl_f <= `DDRI_CL_MAX);
  wire wrr_ok = (wr_f >= `DDRI_WR_MIN) && (wr_f <= `DDRI_WR_MAX);
  wire cfg_ok = bl_ok && cl_ok && wrr_ok;
  wire start_req = wr && sel_ctrl && i_pwdata[`DDRI_CTRL_START] && idle;
  wire start_ok = start_req && cfg_ok;

  // mode values driven on the address pins; always the whole register
  logic [P_ADDR_W-1:0] mr_op;
  logic [P_ADDR_W-1:0] mr_rst;
  logic [P_ADDR_W-1:0] emr_dll;
  logic [P_ADDR_W-1:0] emr_cal1;
  logic [P_ADDR_W-1:0] emr_cal0;
  logic [P_ADDR_W-1:0] pre_all;

  always_comb begin
    mr_op = mr;
    mr_op[`DDRI_TEST_MODE_SELECT_BIT] = 1'b0;
    mr_op[`DDRI_DLL_RELOCK_BIT] = 1'b0;
    mr_rst = mr_op;
    mr_rst[`DDRI_DLL_RELOCK_BIT] = 1'b1;
    emr_cal0 = emr;
    emr_cal0[`DDRI_DRV_CAL_BIT_HIGH:`DDRI_DRV_CAL_BIT_LOW] = 3'h0;
    emr_cal1 = emr;
    emr_cal1[`DDRI_DRV_CAL_BIT_HIGH:`DDRI_DRV_CAL_BIT_LOW] = 3'h7;
    emr_dll = emr_cal0;
    emr_dll[`DDRI_EMR_DLL_BIT] = 1'b0;
    pre_all = '0;
    pre_all[`DDRI_PRE_ALL_BIT] = 1'b1;
  end

  // wait between commands and the dll lock wait
  logic wait_zero;
  logic dll_zero;
  wire issue = tick && wait_zero && busy && (state != ddri_pkg::ST_POWER)
               && (state != ddri_pkg::ST_DLL_WAIT);
  wire power_done = tick && wait_zero && (state == ddri_pkg::ST_POWER);
  wire ready_now = tick && wait_zero && dll_zero && (state == ddri_pkg::ST_DLL_WAIT);
  wire wait_load = start_ok || issue || power_done;
  wire [P_WAIT_W-1:0] wait_val = start_ok ? LD_INIT : (power_done ? LD_PRE : next_gap);

  ddri_tick_cnt #(.P_W(P_WAIT_W)) u_gap_wait (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_tick(tick),
    .i_load(wait_load),
    .i_load_val(wait_val),
    .o_zero(wait_zero)
  );

  ddri_tick_cnt #(.P_W(P_WAIT_W)) u_dll_wait (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_tick(tick),
    .i_load(issue && next_dll_load),
    .i_load_val(LD_DLL),
    .o_zero(dll_zero)
  );

  // command each state issues, where it goes and the gap that follows
  always_comb begin
    next_state = state;
    next_cmd = `DDRI_CMD_NOP;
    next_ba = 2'h0;
    next_addr = '0;
    next_gap = LD_MRD;
    next_dll_load = 1'b0;
    case (state)
      ddri_pkg::ST_PREA1: begin
        next_cmd = `DDRI_CMD_PRE;
        next_addr = pre_all;
        next_gap = LD_RP;
        next_state = ddri_pkg::ST_EMR2;
      end
      ddri_pkg::ST_EMR2: begin
        next_cmd = `DDRI_CMD_LM;
        next_ba = `DDRI_BA_EMR2;
        next_addr = emr2;
        next_state = ddri_pkg::ST_EMR3;
      end
      ddri_pkg::ST_EMR3: begin
        next_cmd = `DDRI_CMD_LM;
        next_ba = `DDRI_BA_EMR3;
        next_addr = emr3;
        next_state = ddri_pkg::ST_EMR_DLL;
      end
      ddri_pkg::ST_EMR_DLL: begin
        next_cmd = `DDRI_CMD_LM;
        next_ba = `DDRI_BA_EMR;
        next_addr = emr_dll;
        next_state = ddri_pkg::ST_MR_RST;
      end
      ddri_pkg::ST_MR_RST: begin
        next_cmd = `DDRI_CMD_LM;
        next_ba = `DDRI_BA_MR;
        next_addr = mr_rst;
        next_dll_load = 1'b1;
        next_state = ddri_pkg::ST_PREA2;
      end
      ddri_pkg::ST_PREA2: begin
        next_cmd = `DDRI_CMD_PRE;
        next_addr = pre_all;
        next_gap = LD_RP;
        next_state = ddri_pkg::ST_REF;
      end
      ddri_pkg::ST_REF: begin
        next_cmd = `DDRI_CMD_REF;
        next_gap = LD_RFC;
        next_state = (ref_cnt == `DDRI_REF_COUNT - 2'h1) ? ddri_pkg::ST_WR_DUMMY
                                                       : ddri_pkg::ST_REF;
      end
      ddri_pkg::ST_WR_DUMMY: begin
        next_cmd = `DDRI_CMD_WRITE;
        next_gap = LD_WGAP;
        next_state = ddri_pkg::ST_MR_OP;
      end
      ddri_pkg::ST_MR_OP: begin
        next_cmd = `DDRI_CMD_LM;
        next_ba = `DDRI_BA_MR;
        next_addr = mr_op;
        next_state = ddri_pkg::ST_EMR_CAL1;
      end
      ddri_pkg::ST_EMR_CAL1: begin
        next_cmd = `DDRI_CMD_LM;
        next_ba = `DDRI_BA_EMR;
        next_addr = emr_cal1;
        next_state = ddri_pkg::ST_EMR_CAL0;
      end
      ddri_pkg::ST_EMR_CAL0: begin
        next_cmd = `DDRI_CMD_LM;
        next_ba = `DDRI_BA_EMR;
        next_addr = emr_cal0;
        next_state = ddri_pkg::ST_DLL_WAIT;
      end
      default: begin
        next_state = state;
      end
    endcase
  end

  // divided memory clock
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt <= '0;
      o_ck <= 1'b1;
      o_ck_n <= 1'b0;
    end else if (i_ce) begin
      div_cnt <= next_div;
      o_ck <= ck_high;
      o_ck_n <= !ck_high;
    end
  end

  // sequencer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ddri_pkg::ST_OFF;
      ref_cnt <= 2'h0;
    end else if (i_ce) begin
      if (start_ok) begin
        state <= ddri_pkg::ST_POWER;
        ref_cnt <= 2'h0;
      end else if (power_done) begin
        state <= ddri_pkg::ST_PREA1;
      end else if (ready_now) begin
        state <= ddri_pkg::ST_READY;
      end else if (issue) begin
        state <= next_state;
        if (state == ddri_pkg::ST_REF) begin
          ref_cnt <= ref_cnt + 2'h1;
        end
      end
    end
  end

  // command pins; cke low from reset until the first start and while the power-up nop wait runs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cke <= 1'b0;
      o_odt <= 1'b0;
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= `DDRI_CMD_NOP;
      o_ba <= 2'h0;
      o_addr <= '0;
    end else if (i_ce) begin
      o_odt <= 1'b0;
      if (start_ok) begin
        o_cke <= 1'b0;
      end else if (power_done) begin
        o_cke <= 1'b1;
      end
      if (tick) begin
        {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= issue ? next_cmd : `DDRI_CMD_NOP;
        o_ba <= issue ? next_ba : 2'h0;
        o_addr <= issue ? next_addr : '0;
      end
    end
  end

  // apb register file
  wire [31:0] stat_word = {28'h0, o_cke, cfg_err, (state == ddri_pkg::ST_READY), busy};
  wire [31:0] rd_mux =
    sel_ctrl ? 32'h0 :
    sel_stat ? stat_word :
    sel_mr ? {{(32 - P_ADDR_W){1'b0}}, mr} :
    sel_emr ? {{(32 - P_ADDR_W){1'b0}}, emr} :
    sel_emr2 ? {{(32 - P_ADDR_W){1'b0}}, emr2} :
    sel_emr3 ? {{(32 - P_ADDR_W){1'b0}}, emr3} : 32'h0;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
    end else if (i_ce) begin
      o_pready <= i_psel && i_penable && !o_pready;
      o_prdata <= rd_mux;
      o_pslverr <= i_psel && i_penable && !o_pready && !mapped;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mr <= `DDRI_MR_RST;
      emr <= `DDRI_EMR_RST;
      emr2 <= `DDRI_EMR2_RST;
      emr3 <= `DDRI_EMR3_RST;
      cfg_err <= 1'b0;
    end else if (i_ce) begin
      if (wr_mode && sel_mr) begin
        mr <= i_pwdata[P_ADDR_W-1:0];
      end
      if (wr_mode && sel_emr) begin
        emr <= i_pwdata[P_ADDR_W-1:0];
      end
      if (wr_mode && sel_emr2) begin
        emr2 <= i_pwdata[P_ADDR_W-1:0];
      end
      if (wr_mode && sel_emr3) begin
        emr3 <= i_pwdata[P_ADDR_W-1:0];
      end
      // a refused start flags the bad field set; a good start clears it
      if (start_req) begin
        cfg_err <= !cfg_ok;
      end
    end
  end
endmodule : ddri_init_ctrl

// ### rtl/ddri_consts.svh
// constants for the ddr2 power-up initialisation controller
`ifndef DDRI_CONSTS_SVH
`define DDRI_CONSTS_SVH

// apb register offsets
`define DDRI_OFF_CTRL 8'h00
`define DDRI_OFF_STATUS 8'h04
`define DDRI_OFF_MR 8'h08
`define DDRI_OFF_EMR 8'h0c
`define DDRI_OFF_EMR2 8'h10
`define DDRI_OFF_EMR3 8'h14

// register bits
`define DDRI_CTRL_START 0
`define DDRI_STAT_BUSY 0
`define DDRI_STAT_READY 1
`define DDRI_STAT_CFG_ERR 2
`define DDRI_STAT_CKE 3

// reset values: burst of 4, sequential, cl 4, write recovery 3
`define DDRI_MR_RST 13'h0442
`define DDRI_EMR_RST 13'h0000
`define DDRI_EMR2_RST 13'h0000
`define DDRI_EMR3_RST 13'h0000

// mode register fields
`define DDRI_BL_LSB 0
`define DDRI_BL_MSB 2
`define DDRI_BL_4 3'h2
`define DDRI_BL_8 3'h3
`define DDRI_CL_LSB 4
`define DDRI_CL_MSB 6
`define DDRI_CL_MIN 3'h3
`define DDRI_CL_MAX 3'h6
`define DDRI_TEST_MODE_SELECT_BIT 7
`define DDRI_DLL_RELOCK_BIT 8
`define DDRI_WR_LSB 9
`define DDRI_WR_MSB 11
`define DDRI_WR_MIN 3'h1
`define DDRI_WR_MAX 3'h5

// extended mode register fields and the precharge all address bit
`define DDRI_EMR_DLL_BIT 0
`define DDRI_DRV_CAL_BIT_LOW 7
`define DDRI_DRV_CAL_BIT_HIGH 9
`define DDRI_PRE_ALL_BIT 10

// bank selects
`define DDRI_BA_MR 2'h0
`define DDRI_BA_EMR 2'h1
`define DDRI_BA_EMR2 2'h2
`define DDRI_BA_EMR3 2'h3

// commands as {cs_n, ras_n, cas_n, we_n}
`define DDRI_CMD_NOP 4'h7
`define DDRI_CMD_LM 4'h0
`define DDRI_CMD_PRE 4'h2
`define DDRI_CMD_REF 4'h1
`define DDRI_CMD_WRITE 4'h4

// timing
`define DDRI_CLK_NS 4
`define DDRI_CK_DIV 8
`define DDRI_T_INIT_NS 200000
`define DDRI_T_PRE_NS 400
`define DDRI_DLL_CK 200
`define DDRI_MODE_SET_DELAY_CK 2
`define DDRI_RP_CK 4
`define DDRI_RFC_CK 8
`define DDRI_WRITE_GAP_CK 8
`define DDRI_REF_COUNT 2'h2

`endif

// ### rtl/ddri_pkg.sv
// types for the ddr2 power-up initialisation controller
package ddri_pkg;
  typedef enum logic [3:0] {
    ST_OFF,
    ST_POWER,
    ST_PREA1,
    ST_EMR2,
    ST_EMR3,
    ST_EMR_DLL,
    ST_MR_RST,
    ST_PREA2,
    ST_REF,
    ST_WR_DUMMY,
    ST_MR_OP,
    ST_EMR_CAL1,
    ST_EMR_CAL0,
    ST_DLL_WAIT,
    ST_READY
  } ddri_state_t;
endpackage : ddri_pkg

// ### rtl/ddri_tick_cnt.sv
// down counter stepped by memory clock ticks
module ddri_tick_cnt #(
  parameter int P_W = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // control
  input wire logic i_tick,
  input wire logic i_load,
  input wire logic [P_W-1:0] i_load_val,
  // status
  output logic o_zero
);
  logic [P_W-1:0] cnt;

  assign o_zero = (cnt == '0);

  // load wins over a step so a fresh wait is never shortened
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= '0;
    end else if (i_ce) begin
      if (i_load) begin
        cnt <= i_load_val;
      end else if (i_tick && !o_zero) begin
        cnt <= cnt - P_W'(1);
      end
    end
  end
endmodule : ddri_tick_cnt

// ### test/ddri_init_ctrl_monitor.sv
// concurrent checks on the ddr2 init controller ports
module ddri_init_ctrl_monitor #(
  parameter int P_ADDR_W = 13
) (
  // clock, reset and apb handshake
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // memory pins
  input wire logic o_ck,
  input wire logic o_ck_n,
  input wire logic o_cke,
  input wire logic o_odt,
  input wire logic o_cs_n,
  input wire logic o_ras_n,
  input wire logic o_cas_n,
  input wire logic o_we_n,
  input wire logic [1:0] o_ba,
  input wire logic [P_ADDR_W-1:0] o_addr
);
  wire logic [3:0] cmd;
  assign cmd = {o_cs_n, o_ras_n, o_cas_n, o_we_n};
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_odt_held_low: assert property (o_odt == 1'b0)
    else $error("odt driven high");
  a_nop_cke_low: assert property (!o_cke |-> cmd == 4'h7 && o_ba == 2'h0 && o_addr == '0)
    else $error("command while cke low");
  a_ck_pair: assert property ($rose(o_ck) |-> (o_ck && !o_ck_n)[*4] ##1 (!o_ck && o_ck_n)[*4] ##1 o_ck)
    else $error("memory clock shape wrong");
  a_cmd_on_fall: assert property ($changed({cmd, o_ba, o_addr}) |-> $fell(o_ck))
    else $error("command changed off the clock fall");
  a_lm_spacing: assert property ($rose(o_ck) && cmd == 4'h0 |-> ##8 cmd == 4'h7)
    else $error("command too soon after load mode");
  a_pre_all_bit: assert property (cmd == 4'h2 |-> o_addr[10])
    else $error("precharge without all-bank bit");
  a_mr_test_zero: assert property (cmd == 4'h0 && o_ba == 2'h0 |-> !o_addr[7])
    else $error("test mode bit written");
  // one wait state, always
  a_apb_wait: assert property ($rose(i_penable) && i_psel |=> o_pready)
    else $error("apb answer late");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
endmodule : ddri_init_ctrl_monitor

// ### test/ddri_mem_model.sv
// behavioural ddr2 device model driven by the controller pins
module ddri_mem_model #(
  parameter int P_INIT_CK = 6250,
  parameter int P_PRE_CK = 13,
  parameter int P_DLL_CK = 200,
  parameter int P_ADDR_W = 13
) (
  // reset and memory clock
  input wire logic i_rst,
  input wire logic i_ck,
  // command pins
  input wire logic i_cke,
  input wire logic i_odt,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [1:0] i_ba,
  input wire logic [P_ADDR_W-1:0] i_addr,
  // device state
  output logic o_ready
);
  logic [3:0] log_cmd [0:31];
  logic [1:0] log_ba [0:31];
  logic [P_ADDR_W-1:0] log_addr [0:31];
  logic [P_ADDR_W-1:0] mode_reg [0:3];
  int n_cmd;
  int viol;
  int low_ck;
  int high_ck;
  int dll_ck;
  wire logic [3:0] cmd;
  assign cmd = {i_cs_n, i_ras_n, i_cas_n, i_we_n};

  // column of each beat; the block stays aligned and accesses wrap inside it
  function automatic logic [2:0] beat_col(input logic bl8, input logic ilv,
                                          input logic [2:0] start, input logic [2:0] beat);
    logic [2:0] c;
    c = ilv ? (start ^ beat) : (start + beat);
    return bl8 ? c : {start[2], c[1:0]};
  endfunction : beat_col

  // commands are registered on the memory clock rise only
  always @(posedge i_ck or posedge i_rst) begin
    if (i_rst) begin
      n_cmd = 0;
      viol = 0;
      low_ck = 0;
      high_ck = 0;
      dll_ck = 0;
      o_ready = 1'b0;
      mode_reg = '{default: '0};
    end else begin
      if (i_odt !== 1'b0) viol++;
      // the relock command's own edge counts as the first clock
      if (dll_ck > 0 && dll_ck < P_DLL_CK) dll_ck++;
      o_ready = (dll_ck >= P_DLL_CK);
      if (i_cke !== 1'b1) begin
        if (cmd !== 4'h7) viol++;
        low_ck++;
        high_ck = 0;
      end else if (cmd === 4'h7) begin
        high_ck++;
      end else begin
        if (n_cmd % 12 == 0 && (low_ck < P_INIT_CK || high_ck < P_PRE_CK)) viol++;
        if (n_cmd % 12 == 0) low_ck = 0;
        log_cmd[n_cmd] = cmd;
        log_ba[n_cmd] = i_ba;
        log_addr[n_cmd] = i_addr;
        n_cmd++;
        // a test mode write programs nothing, so the old value stays
        if (cmd === 4'h0 && !(i_ba == 2'h0 && i_addr[7])) mode_reg[i_ba] = i_addr;
        if (cmd === 4'h0 && i_ba == 2'h0 && i_addr[8]) begin
          mode_reg[0][8] = 1'b0;
          dll_ck = 1;
          o_ready = 1'b0;
        end
      end
    end
  end
endmodule : ddri_mem_model

// ### test/ddri_init_ctrl_tb_top.sv
// self-checking bench for the ddr2 init controller
`include "ddri_consts.svh"

module ddri_init_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P_DLL = 60;
  // burst of 8, interleaved, cl 5, wr code 3, fast exit off; test and relock bits set on purpose
  localparam logic [12:0] mr_val = 13'h17db;
  localparam logic [12:0] emr_val = 13'h0044;
  localparam logic [12:0] emr2_val = 13'h00a5;
  localparam logic [12:0] emr3_val = 13'h005a;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_ck, o_ck_n, o_cke, o_odt, o_cs_n, o_ras_n, o_cas_n, o_we_n;
  logic [1:0] o_ba;
  logic [12:0] o_addr;
  logic mem_ready;
  int failures = 0;
  int cmp_count = 0;

  ddri_init_ctrl #(.P_INIT_CK(20), .P_DLL_CK(P_DLL)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_ck(o_ck), .o_ck_n(o_ck_n), .o_cke(o_cke),
    .o_odt(o_odt), .o_cs_n(o_cs_n), .o_ras_n(o_ras_n), .o_cas_n(o_cas_n), .o_we_n(o_we_n),
    .o_ba(o_ba), .o_addr(o_addr)
  );
  ddri_mem_model #(.P_INIT_CK(20), .P_DLL_CK(P_DLL)) u_mem (
    .i_rst(i_rst), .i_ck(o_ck), .i_cke(o_cke), .i_odt(o_odt), .i_cs_n(o_cs_n),
    .i_ras_n(o_ras_n), .i_cas_n(o_cas_n), .i_we_n(o_we_n), .i_ba(o_ba), .i_addr(o_addr),
    .o_ready(mem_ready)
  );

  initial begin
    forever #2 i_clk = ~i_clk;
  end

  task automatic finish_test();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held from setup until the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t apb answer missing", $time);
      finish_test();
    end else begin
      q = o_prdata;
      e = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk(e, 32'h0);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic er);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk(e, er);
  endtask : rd_chk

  task automatic wait_ready();
    logic [31:0] q;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, `DDRI_OFF_STATUS, 32'h0, q, e);
      n++;
    end while (q[1] !== 1'b1 && n < 600);
    if (q[1] !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t ready never seen", $time);
      finish_test();
    end
  endtask : wait_ready

  task automatic chk_seq(input int b);
    logic [3:0] ec [0:11];
    logic [1:0] eb [0:11];
    logic [12:0] ea [0:11];
    ec = '{4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h1, 4'h1, 4'h4, 4'h0, 4'h0, 4'h0};
    eb = '{2'h0, 2'h2, 2'h3, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1};
    ea = '{13'h0, emr2_val, emr3_val, emr_val & ~13'h0381, (mr_val | 13'h0100) & ~13'h0080,
           13'h0, 13'h0, 13'h0, 13'h0, mr_val & ~13'h0180, emr_val | 13'h0380,
           emr_val & ~13'h0380};
    for (int i = 0; i < 12; i++) begin
      chk(u_mem.log_cmd[b+i], ec[i]);
      if (ec[i] == 4'h0 || ec[i] == 4'h4) chk(u_mem.log_addr[b+i], ea[i]);
      if (ec[i] == 4'h0) chk(u_mem.log_ba[b+i], eb[i]);
    end
  endtask : chk_seq

  task automatic t_regs();
    rd_chk(`DDRI_OFF_MR, 32'h0442, 1'b0);
    rd_chk(`DDRI_OFF_EMR, 32'h0, 1'b0);
    rd_chk(`DDRI_OFF_STATUS, 32'h0, 1'b0);
    rd_chk(8'h18, 32'h0, 1'b1);
  endtask : t_regs

  // beat orders from start column 5, both lengths and both types
  task automatic t_burst();
    logic [23:0] q [0:3];
    for (int k = 0; k < 4; k++) begin
      q[k] = 24'h0;
      for (int b = 0; b < (k > 1 ? 8 : 4); b++) begin
        q[k] = {q[k][20:0], u_mem.beat_col(k[1], k[0], 3'h5, b[2:0])};
      end
    end
    chk(q[0], 32'hbbc);
    chk(q[1], 32'hb3e);
    chk(q[2], 32'hbb829c);
    chk(q[3], 32'hb3e21a);
  endtask : t_burst

  // reserved burst length code must not start a run
  task automatic t_bad_cfg();
    wr(`DDRI_OFF_MR, 32'h0441);
    wr(`DDRI_OFF_CTRL, 32'h1);
    rd_chk(`DDRI_OFF_STATUS, 32'h4, 1'b0);
    chk(u_mem.n_cmd, 32'h0);
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask : t_bad_cfg

  task automatic t_init();
    wr(`DDRI_OFF_MR, {19'h0, mr_val});
    wr(`DDRI_OFF_EMR, {19'h0, emr_val});
    wr(`DDRI_OFF_EMR2, {19'h0, emr2_val});
    wr(`DDRI_OFF_EMR3, {19'h0, emr3_val});
    wr(`DDRI_OFF_CTRL, 32'h1);
    rd_chk(`DDRI_OFF_STATUS, 32'h1, 1'b0);
    wr(`DDRI_OFF_MR, 32'h0);
    rd_chk(`DDRI_OFF_MR, {19'h0, mr_val}, 1'b0);
    wait_ready();
    chk(mem_ready, 32'h1);
    rd_chk(`DDRI_OFF_STATUS, 32'ha, 1'b0);
    chk(u_mem.viol, 32'h0);
    chk(u_mem.n_cmd, 32'd12);
    chk_seq(0);
    chk(u_mem.mode_reg[0], mr_val & ~13'h0180);
  endtask : t_init

  task automatic t_rerun();
    wr(`DDRI_OFF_CTRL, 32'h1);
    rd_chk(`DDRI_OFF_STATUS, 32'h1, 1'b0);
    wait_ready();
    chk(u_mem.viol, 32'h0);
    chk(u_mem.n_cmd, 32'd24);
    chk_seq(12);
  endtask : t_rerun

  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs();
    t_burst();
    t_bad_cfg();
    t_init();
    t_rerun();
    finish_test();
  end
endmodule : ddri_init_ctrl_tb_top

bind ddri_init_ctrl ddri_init_ctrl_monitor #(.P_ADDR_W(P_ADDR_W)) u_mon (
  .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_ck(o_ck), .o_ck_n(o_ck_n), .o_cke(o_cke), .o_odt(o_odt),
  .o_cs_n(o_cs_n), .o_ras_n(o_ras_n), .o_cas_n(o_cas_n), .o_we_n(o_we_n), .o_ba(o_ba),
  .o_addr(o_addr)
);
